/* core/cdw_axil_slave.sv */
// AXI4-Lite slave front end turning bus beats into register strobes
`timescale 1ns/1ps
`default_nettype none
module cdw_axil_slave (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Write address and data
  input  wire logic [31:0] awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  // Write response
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  // Read channels
  input  wire logic [31:0] araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // Register side
  cdw_reg_if.bus           rb
);
  logic        aw_held;
  logic        w_held;
  logic [3:0]  strb;
  logic        fire_wr;

  assign awready_o = !aw_held;
  assign wready_o  = !w_held;
  assign arready_o = !rvalid_o;
  assign fire_wr   = aw_held && w_held && !bvalid_o;

  // Strobes toward the register file
  assign rb.wr_stb  = fire_wr;
  assign rb.wr_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  assign rb.rd_stb  = arvalid_i && !rvalid_o;
  assign rb.rd_addr = araddr_i;

  // Hold address and data independently until both are present
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      rb.wr_addr <= 32'h0000_0000;
      rb.wr_data <= 32'h0000_0000;
      strb       <= 4'h0;
    end else begin
      if (awvalid_i && !aw_held) begin
        aw_held    <= 1'b1;
        rb.wr_addr <= awaddr_i;
      end else if (fire_wr) begin
        aw_held <= 1'b0;
      end
      if (wvalid_i && !w_held) begin
        w_held     <= 1'b1;
        rb.wr_data <= wdata_i;
        strb       <= wstrb_i;
      end else if (fire_wr) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, error for offsets without a writable register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= cdw_pkg::RESP_OKAY;
    end else if (fire_wr) begin
      bvalid_o <= 1'b1;
      bresp_o  <= rb.wr_hit ? cdw_pkg::RESP_OKAY : cdw_pkg::RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= 32'h0000_0000;
      rresp_o  <= cdw_pkg::RESP_OKAY;
    end else if (rb.rd_stb) begin
      rvalid_o <= 1'b1;
      rdata_o  <= rb.rd_hit ? rb.rd_data : 32'h0000_0000;
      rresp_o  <= rb.rd_hit ? cdw_pkg::RESP_OKAY : cdw_pkg::RESP_SLVERR;
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* core/cdw_pkg.sv */
// Constants, field layout and types of the descriptor walker
package cdw_pkg;
  // Register byte offsets
  localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFF_BASE = 32'h0000_0004;
  localparam logic [31:0] OFF_CURR = 32'h0000_0008;
  localparam logic [31:0] OFF_POLL = 32'h0000_000C;
  localparam logic [31:0] OFF_STAT = 32'h0000_0010;
  localparam logic [31:0] OFF_MASK = 32'h0000_0014;
  localparam logic [31:0] OFF_INFO = 32'h0000_0018;
  // Control register bits
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_RX_BIT  = 1;
  // Descriptor control word fields
  localparam int OWNER_BIT     = 31;
  localparam int OPK_HI        = 29;
  localparam int OPK_LO        = 27;
  localparam int CTX_FETCH_BIT = 22;
  localparam int CHAIN_END_BIT = 19;
  localparam int FRAME_END_BIT = 18;
  localparam int PKT_IRQ_BIT   = 17;
  localparam int DESC_IRQ_BIT  = 16;
  localparam int LEN_HI        = 15;
  // Descriptor word indices
  localparam logic [2:0] W_CTRL = 3'h0;
  localparam logic [2:0] W_CTX  = 3'h1;
  localparam logic [2:0] W_SRC  = 3'h2;
  localparam logic [2:0] W_DST  = 3'h3;
  localparam logic [2:0] W_NEXT = 3'h4;
  localparam logic [2:0] W_RES  = 3'h5;
  localparam int         N_WORDS = 6;
  // Status bits
  localparam int ST_DESC  = 0;
  localparam int ST_PKT   = 1;
  localparam int ST_BADOP = 2;
  localparam int ST_WRAP  = 3;
  localparam int ST_W     = 4;
  // Reset values
  localparam logic [1:0]  RST_CTRL = 2'h0;
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [15:0] RST_POLL = 16'h0000;
  localparam logic [3:0]  RST_MASK = 4'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Operation kinds
  typedef enum logic [2:0] {
    OP_NORMAL       = 3'h0,
    OP_PREBOOT_AUTH = 3'h1,
    OP_KEY_ENC_KEY  = 3'h2,
    OP_CONTENT_KEY  = 3'h3
  } cdw_op_t;
  // Walker states
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_FETCH = 8'h02,
    S_POLL  = 8'h04,
    S_JOB   = 8'h08,
    S_BUSY  = 8'h10,
    S_RES   = 8'h20,
    S_WB    = 8'h40,
    S_DONE  = 8'h80
  } cdw_state_t;
endpackage

/* core/cdw_poll_timer.sv */
// Reloadable down counter for the ownership poll wait
`timescale 1ns/1ps
`default_nettype none
module cdw_poll_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              expired_o
);
  logic [W-1:0] cnt;
  logic         armed;

  // Count down from the loaded value
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt   <= '0;
      armed <= 1'b0;
    end else if (load_i) begin
      cnt   <= value_i;
      armed <= 1'b1;
    end else if (armed && cnt != '0) begin
      cnt <= cnt - 1'b1;
    end else begin
      armed <= 1'b0;
    end
  end

  // High in the cycle the count reaches zero
  assign expired_o = armed && (cnt == '0);
endmodule
`default_nettype wire

/* core/cdw_reg_if.sv */
// Simple register access path between bus slave and walker
`timescale 1ns/1ps
`default_nettype none
interface cdw_reg_if;
  logic        wr_stb;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;
  logic        wr_hit;
  logic        rd_stb;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_hit;
  modport bus  (output wr_stb, wr_addr, wr_data, wr_mask, rd_stb, rd_addr,
                input  wr_hit, rd_data, rd_hit);
  modport regs (input  wr_stb, wr_addr, wr_data, wr_mask, rd_stb, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

/* core/cdw_walker.sv */
// Crypto DMA descriptor walker with AXI4-Lite registers
// Overview of operation
// - Clear owner flag after finishing descriptor
// - Decode operation kind, 100 to 111 reserved
// - Context fetch bit loads or reuses context
// - Chain end reloads current from base
// - Receive path writes frame end flag
// - Packet interrupt only at packet end
// - Per-descriptor interrupt after each descriptor with its interrupt bit set
// - Receive path writes back filled length
// - Whole context word is session address
// - Follow next pointer to following descriptor
// - Post results at result pointer
// - Unowned descriptor waits poll interval, refetches
// - Descriptors updated in place in memory
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cdw_walker (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // AXI4-Lite register slave
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // System memory master
  output logic             mem_valid_o,
  output logic             mem_write_o,
  output logic [31:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  input  wire logic        mem_ready_i,
  input  wire logic [31:0] mem_rdata_i,
  // Job to the cipher and hash engines
  output logic             job_valid_o,
  input  wire logic        job_ready_i,
  output logic [2:0]       job_op_kind_o,
  output logic             job_ctx_load_o,
  output logic [31:0]      job_ctx_ptr_o,
  output logic [31:0]      job_src_o,
  output logic [31:0]      job_dst_o,
  output logic [15:0]      job_len_o,
  input  wire logic        job_done_i,
  input  wire logic [15:0] job_filled_len_i,
  input  wire logic        job_frame_end_i,
  input  wire logic [31:0] job_result_i,
  // Interrupt
  output logic             irq_o
);
  cdw_pkg::cdw_state_t state;
  cdw_pkg::cdw_state_t next_state;

  logic [31:0] desc [cdw_pkg::N_WORDS];
  logic [2:0]  wi;
  logic [1:0]  ctrl;
  logic [31:0] base;
  logic [31:0] cur;
  logic [15:0] poll;
  localparam int ST_W_M1 = cdw_pkg::ST_W - 1;
  logic [ST_W_M1:0] status;
  logic [3:0]  mask;
  logic [31:0] ctx_active;
  logic        ctx_load;
  logic [15:0] filled;
  logic        fe_cap;
  logic [31:0] res_cap;
  logic        bad_op;
  logic        fe_eff;
  logic [31:0] wb_word;
  logic [3:0]  ev;
  logic        poll_load;
  logic        poll_expired;
  logic [15:0] poll_val;
  logic        stat_rd;

  cdw_reg_if rb ();

  // Bus front end
  cdw_axil_slave u_slave (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .awaddr_i  (s_axi_awaddr_i),
    .awvalid_i (s_axi_awvalid_i),
    .awready_o (s_axi_awready_o),
    .wdata_i   (s_axi_wdata_i),
    .wstrb_i   (s_axi_wstrb_i),
    .wvalid_i  (s_axi_wvalid_i),
    .wready_o  (s_axi_wready_o),
    .bresp_o   (s_axi_bresp_o),
    .bvalid_o  (s_axi_bvalid_o),
    .bready_i  (s_axi_bready_i),
    .araddr_i  (s_axi_araddr_i),
    .arvalid_i (s_axi_arvalid_i),
    .arready_o (s_axi_arready_o),
    .rdata_o   (s_axi_rdata_o),
    .rresp_o   (s_axi_rresp_o),
    .rvalid_o  (s_axi_rvalid_o),
    .rready_i  (s_axi_rready_i),
    .rb        (rb.bus)
  );

  // Poll wait, at least one cycle
  assign poll_val = (poll == 16'h0000) ? 16'h0000 : poll - 16'h0001;
  cdw_poll_timer #(.W(16)) u_poll (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .load_i    (poll_load),
    .value_i   (poll_val),
    .expired_o (poll_expired)
  );

  // Reserved operation kinds are refused
  assign bad_op = desc[cdw_pkg::W_CTRL][cdw_pkg::OPK_HI];
  // Frame end from engine on receive, from descriptor on transmit
  assign fe_eff = ctrl[cdw_pkg::CTRL_RX_BIT] ? fe_cap
                : desc[cdw_pkg::W_CTRL][cdw_pkg::FRAME_END_BIT];

  // Control word handed back to software
  always_comb begin
    wb_word = desc[cdw_pkg::W_CTRL];
    wb_word[cdw_pkg::OWNER_BIT] = 1'b0;
    if (ctrl[cdw_pkg::CTRL_RX_BIT] && !bad_op) begin
      wb_word[cdw_pkg::LEN_HI:0] = filled;
      wb_word[cdw_pkg::FRAME_END_BIT] = fe_cap;
    end
  end

  // Next state of the walker
  always_comb begin
    next_state = state;
    poll_load  = 1'b0;
    unique case (state)
      cdw_pkg::S_IDLE: begin
        if (ctrl[cdw_pkg::CTRL_RUN_BIT]) begin
          next_state = cdw_pkg::S_FETCH;
        end
      end
      cdw_pkg::S_FETCH: begin
        if (mem_ready_i) begin
          if (wi == cdw_pkg::W_CTRL && !mem_rdata_i[cdw_pkg::OWNER_BIT]) begin
            next_state = cdw_pkg::S_POLL;
            poll_load  = 1'b1;
          end else if (wi == cdw_pkg::W_RES) begin
            next_state = bad_op ? cdw_pkg::S_WB : cdw_pkg::S_JOB;
          end
        end
      end
      cdw_pkg::S_POLL: begin
        if (poll_expired) begin
          next_state = cdw_pkg::S_FETCH;
        end
      end
      cdw_pkg::S_JOB: begin
        if (job_ready_i) begin
          next_state = cdw_pkg::S_BUSY;
        end
      end
      cdw_pkg::S_BUSY: begin
        if (job_done_i) begin
          next_state = cdw_pkg::S_RES;
        end
      end
      cdw_pkg::S_RES: begin
        if (mem_ready_i) begin
          next_state = cdw_pkg::S_WB;
        end
      end
      cdw_pkg::S_WB: begin
        if (mem_ready_i) begin
          next_state = cdw_pkg::S_DONE;
        end
      end
      cdw_pkg::S_DONE: begin
        next_state = cdw_pkg::S_IDLE;
      end
      default: begin
        next_state = cdw_pkg::S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= cdw_pkg::S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Descriptor word capture and word index
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wi <= cdw_pkg::W_CTRL;
      for (int i = 0; i < cdw_pkg::N_WORDS; i++) begin
        desc[i] <= 32'h0000_0000;
      end
    end else if (state == cdw_pkg::S_FETCH && mem_ready_i) begin
      desc[wi] <= mem_rdata_i;
      if (next_state == cdw_pkg::S_FETCH) begin
        wi <= wi + 3'h1;
      end else begin
        wi <= cdw_pkg::W_CTRL;
      end
    end
  end

  // Memory address and write data, descriptor words in place, result at result pointer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_addr_o  <= 32'h0000_0000;
      mem_wdata_o <= 32'h0000_0000;
    end else if (next_state == cdw_pkg::S_FETCH) begin
      mem_addr_o <= cur + {27'h0, next_wi(), 2'h0};
    end else if (next_state == cdw_pkg::S_RES && state != cdw_pkg::S_RES) begin
      mem_addr_o  <= desc[cdw_pkg::W_RES];
      mem_wdata_o <= job_result_i;
    end else if (next_state == cdw_pkg::S_WB && state != cdw_pkg::S_WB) begin
      mem_addr_o  <= cur;
      mem_wdata_o <= wb_word;
    end
  end

  // Index of the word fetched in the next cycle
  function automatic logic [2:0] next_wi();
    next_wi = (state != cdw_pkg::S_FETCH) ? cdw_pkg::W_CTRL
            : mem_ready_i ? wi + 3'h1 : wi;
  endfunction

  // Memory handshake follows the state
  assign mem_valid_o = state == cdw_pkg::S_FETCH || state == cdw_pkg::S_RES
                    || state == cdw_pkg::S_WB;
  assign mem_write_o = state == cdw_pkg::S_RES || state == cdw_pkg::S_WB;

  // Security context: load new pointer or keep the current one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctx_active <= 32'h0000_0000;
      ctx_load   <= 1'b0;
    end else if (state == cdw_pkg::S_FETCH && next_state == cdw_pkg::S_JOB) begin
      ctx_load <= desc[cdw_pkg::W_CTRL][cdw_pkg::CTX_FETCH_BIT];
      if (desc[cdw_pkg::W_CTRL][cdw_pkg::CTX_FETCH_BIT]) begin
        ctx_active <= desc[cdw_pkg::W_CTX];
      end
    end
  end

  // Job toward the engines
  assign job_valid_o    = state == cdw_pkg::S_JOB;
  assign job_op_kind_o  = desc[cdw_pkg::W_CTRL][cdw_pkg::OPK_HI:cdw_pkg::OPK_LO];
  assign job_ctx_load_o = ctx_load;
  assign job_ctx_ptr_o  = ctx_active;
  assign job_src_o      = desc[cdw_pkg::W_SRC];
  assign job_dst_o      = desc[cdw_pkg::W_DST];
  assign job_len_o      = desc[cdw_pkg::W_CTRL][cdw_pkg::LEN_HI:0];

  // Engine completion capture
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      filled  <= 16'h0000;
      fe_cap  <= 1'b0;
      res_cap <= 32'h0000_0000;
    end else if (state == cdw_pkg::S_BUSY && job_done_i) begin
      filled  <= job_filled_len_i;
      fe_cap  <= job_frame_end_i;
      res_cap <= job_result_i;
    end
  end

  // Current descriptor address
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur <= cdw_pkg::RST_BASE;
    end else if (state == cdw_pkg::S_DONE) begin
      if (desc[cdw_pkg::W_CTRL][cdw_pkg::CHAIN_END_BIT]) begin
        cur <= base;
      end else begin
        cur <= desc[cdw_pkg::W_NEXT];
      end
    end else if (state == cdw_pkg::S_IDLE && rb.wr_stb
                 && rb.wr_addr == cdw_pkg::OFF_BASE) begin
      cur <= (base & ~rb.wr_mask) | (rb.wr_data & rb.wr_mask);
    end
  end

  // Software registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= cdw_pkg::RST_CTRL;
      base <= cdw_pkg::RST_BASE;
      poll <= cdw_pkg::RST_POLL;
      mask <= cdw_pkg::RST_MASK;
    end else if (rb.wr_stb) begin
      unique case (rb.wr_addr)
        cdw_pkg::OFF_CTRL: ctrl <= (ctrl & ~rb.wr_mask[1:0])
                                 | (rb.wr_data[1:0] & rb.wr_mask[1:0]);
        cdw_pkg::OFF_BASE: base <= (base & ~rb.wr_mask)
                                 | (rb.wr_data & rb.wr_mask);
        cdw_pkg::OFF_POLL: poll <= (poll & ~rb.wr_mask[15:0])
                                 | (rb.wr_data[15:0] & rb.wr_mask[15:0]);
        cdw_pkg::OFF_MASK: mask <= (mask & ~rb.wr_mask[3:0])
                                 | (rb.wr_data[3:0] & rb.wr_mask[3:0]);
        default: ;
      endcase
    end
  end

  // Events of a finished or refused descriptor
  always_comb begin
    ev = 4'h0;
    if (state == cdw_pkg::S_DONE) begin
      ev[cdw_pkg::ST_DESC] = desc[cdw_pkg::W_CTRL][cdw_pkg::DESC_IRQ_BIT];
      ev[cdw_pkg::ST_PKT]  = desc[cdw_pkg::W_CTRL][cdw_pkg::PKT_IRQ_BIT]
                             && fe_eff && !bad_op;
      ev[cdw_pkg::ST_BADOP] = bad_op;
      ev[cdw_pkg::ST_WRAP]  = desc[cdw_pkg::W_CTRL][cdw_pkg::CHAIN_END_BIT];
    end
  end

  // Sticky status, cleared by read, new events win
  assign stat_rd = rb.rd_stb && rb.rd_addr == cdw_pkg::OFF_STAT;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status <= 4'h0;
    end else begin
      status <= (stat_rd ? 4'h0 : status) | ev;
    end
  end

  assign irq_o = |(status & mask);

  // Register read mux
  always_comb begin
    rb.rd_hit  = 1'b1;
    rb.rd_data = 32'h0000_0000;
    unique case (rb.rd_addr)
      cdw_pkg::OFF_CTRL: rb.rd_data = {30'h0, ctrl};
      cdw_pkg::OFF_BASE: rb.rd_data = base;
      cdw_pkg::OFF_CURR: rb.rd_data = cur;
      cdw_pkg::OFF_POLL: rb.rd_data = {16'h0, poll};
      cdw_pkg::OFF_STAT: rb.rd_data = {28'h0, status};
      cdw_pkg::OFF_MASK: rb.rd_data = {28'h0, mask};
      cdw_pkg::OFF_INFO: rb.rd_data = {16'h0, state, 5'h0, job_op_kind_o};
      default: rb.rd_hit = 1'b0;
    endcase
  end

  // Write decode
  assign rb.wr_hit = rb.wr_addr == cdw_pkg::OFF_CTRL
                  || rb.wr_addr == cdw_pkg::OFF_BASE
                  || rb.wr_addr == cdw_pkg::OFF_POLL
                  || rb.wr_addr == cdw_pkg::OFF_MASK;

  // Result captured but unused; the posting write takes job_result_i
  logic unused_res;
  assign unused_res = ^res_cap;
endmodule
`default_nettype wire

/* test/cdw_mem_model.sv */
// Behavioural system memory holding the descriptor chains
`timescale 1ns/1ps
`default_nettype none
module cdw_mem_model (
  // Clock and stall control
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  // Memory beats
  input  wire logic        valid_i,
  input  wire logic        write_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             ready_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] m [0:63];
  logic [31:0] last = 32'h0;
  logic        tick = 1'b0;
  // Every other cycle stalls when slow
  always @(posedge clk_i) tick <= !tick;
  assign ready_o = !slow_i || tick;
  // Outside a read beat show a changed value, not the last word
  assign rdata_o = (valid_i && !write_i) ? m[addr_i[7:2]] : ~last;
  // Descriptors and results are updated in place
  always @(posedge clk_i) begin
    if (valid_i && ready_o && write_i) m[addr_i[7:2]] <= wdata_i;
    if (valid_i && ready_o && !write_i) last <= rdata_o;
  end
endmodule
`default_nettype wire

/* test/cdw_walker_checker.sv */
// Port checks on the descriptor walker
`timescale 1ns/1ps
`default_nettype none
module cdw_walker_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // Register bus
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  // Memory and engine
  input wire logic        mem_valid_o,
  input wire logic        mem_write_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic        mem_ready_i,
  input wire logic        job_valid_o,
  input wire logic        job_ready_i,
  input wire logic [2:0]  job_op_kind_o,
  input wire logic [31:0] job_src_o,
  input wire logic [15:0] job_len_o,
  input wire logic        job_done_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Requests hold until taken
  a_mem_hold: assert property (mem_valid_o && !mem_ready_i |=>
    mem_valid_o && $stable(mem_addr_o) && $stable(mem_write_o))
    else $error("memory beat changed before ready");
  a_job_hold: assert property (job_valid_o && !job_ready_i |=>
    job_valid_o && $stable(job_src_o) && $stable(job_len_o))
    else $error("job changed before ready");
  a_op_legal: assert property (job_valid_o |-> !job_op_kind_o[2])
    else $error("reserved operation sent to engine");
  // Write after the result write is the control word
  a_owner_clear: assert property ((mem_valid_o && mem_write_o &&
    mem_ready_i ##1 mem_valid_o && mem_write_o) |-> !mem_wdata_o[31])
    else $error("owner flag left set");
  a_result_post: assert property (job_done_i |->
    ##[1:8] mem_valid_o && mem_write_o)
    else $error("no result write after done");
  a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o)
    else $error("read answer late");
  a_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  a_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o)
    else $error("write response dropped");
  // Main scenarios reached
  c_job: cover property (job_valid_o && job_ready_i);
  c_wb: cover property (mem_valid_o && mem_write_o && mem_ready_i);
  c_stall: cover property (mem_valid_o && !mem_ready_i);
endmodule
bind cdw_walker cdw_walker_checker i_chk (.*);
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the descriptor walker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Bench state
  logic        clk_i = 1'b0, nrst_i = 1'b0, slow = 1'b0;
  int          fail_count = 0, samples_checked = 0, n;
  // Register bus
  logic [31:0] aw = '0, wd = '0, ar = '0, rd;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        awr, wrdy, bv, arr, rv;
  logic [1:0]  bresp, rresp;
  // Memory and engine
  logic [31:0] ma, mwd, mrd, jctx, jsrc, jdst, jres = '0;
  logic        mv, mw, mr, jv, jld, irq, jr = 1'b0, jdone = 1'b0, jfe = 1'b0;
  logic [2:0]  jop;
  logic [15:0] jlen, jfill = '0;
  // Owned, 64-bit aligned chain; unused bits zero, ops 0 to 4
  logic [31:0] ctl [5] = '{32'h8041_0010, 32'h8802_0020, 32'h9046_0030,
                           32'h9800_0040, 32'hA008_0050};
  always #25 clk_i = ~clk_i;
  cdw_walker i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .mem_valid_o(mv),
    .mem_write_o(mw), .mem_addr_o(ma), .mem_wdata_o(mwd),
    .mem_ready_i(mr), .mem_rdata_i(mrd), .job_valid_o(jv),
    .job_ready_i(jr), .job_op_kind_o(jop), .job_ctx_load_o(jld),
    .job_ctx_ptr_o(jctx), .job_src_o(jsrc), .job_dst_o(jdst),
    .job_len_o(jlen), .job_done_i(jdone), .job_filled_len_i(jfill),
    .job_frame_end_i(jfe), .job_result_i(jres), .irq_o(irq));
  cdw_mem_model i_mem (.clk_i(clk_i), .slow_i(slow), .valid_i(mv),
    .write_i(mw), .addr_i(ma), .wdata_i(mwd), .ready_o(mr), .rdata_o(mrd));
  // Verdict and end of run
  task print_verdict;
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task limit;
    if (n >= 999) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus write; address and data released each when taken
  task automatic wreg(input logic [31:0] a, d, input logic [1:0] e);
    @(posedge clk_i);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 999);
    br <= 1'b0;
    limit();
    chk(bresp, e);
  endtask
  // Bus read with expected data and response
  task automatic rreg(input logic [31:0] a, x, input logic [1:0] e);
    @(posedge clk_i);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 999);
    rr <= 1'b0;
    limit();
    chk(rd, x);
    chk(rresp, e);
  endtask
  // Engine side: check job, stall i cycles, then report done
  task automatic job(input int i, input logic [31:0] x,
                     input logic [15:0] f, input logic e);
    int w;
    w = 16 + 8 * i;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (jv !== 1'b1 && n < 999);
    limit();
    chk(jop, i_mem.m[w][29:27]);
    chk(jld, i_mem.m[w][22]);
    chk(jctx, x);
    chk(jsrc, i_mem.m[w+2]);
    chk(jdst, i_mem.m[w+3]);
    chk(jlen, i_mem.m[w][15:0]);
    repeat (i) @(posedge clk_i);
    jr <= 1'b1;
    @(posedge clk_i);
    jr <= 1'b0;
    repeat (3) @(posedge clk_i);
    jdone <= 1'b1;
    jres <= 32'h5A00_0000 + i;
    jfill <= f;
    jfe <= e;
    @(posedge clk_i);
    jdone <= 1'b0;
  endtask
  // Wait for the owner flag of a word to drop
  task automatic wm(input int w);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (i_mem.m[w][31] !== 1'b0 && n < 999);
    limit();
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int k = 0; k < 6; k++) rreg(4 * k, 32'h0, cdw_pkg::RESP_OKAY);
    rreg(cdw_pkg::OFF_INFO, 32'h0000_0100, cdw_pkg::RESP_OKAY);
    rreg(32'h0000_001C, 32'h0, cdw_pkg::RESP_SLVERR);
    wreg(cdw_pkg::OFF_CURR, 32'h1, cdw_pkg::RESP_SLVERR);
    for (int i = 0; i < 5; i++) begin
      i_mem.m[16+8*i] = ctl[i];
      i_mem.m[17+8*i] = 32'h3000 + 32'h40 * i;
      i_mem.m[18+8*i] = 32'h1000 + 32'h100 * i;
      i_mem.m[19+8*i] = 32'h2000 + 32'h100 * i;
      i_mem.m[20+8*i] = 32'h60 + 32'h20 * i;
      i_mem.m[21+8*i] = 32'hE0 + 32'h4 * i;
    end
    wreg(cdw_pkg::OFF_POLL, 32'h4, cdw_pkg::RESP_OKAY);
    wreg(cdw_pkg::OFF_BASE, 32'h40, cdw_pkg::RESP_OKAY);
    wreg(cdw_pkg::OFF_CTRL, 32'h1, cdw_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) job(i, 32'h3000 + 32'h80 * (i / 2), 16'h0, 1'b0);
    wm(48);
    chk(irq, 1'b0);
    rreg(cdw_pkg::OFF_CURR, 32'h40, cdw_pkg::RESP_OKAY);
    for (int i = 0; i < 5; i++) chk(i_mem.m[16+8*i], ctl[i] & 32'h7FFF_FFFF);
    for (int i = 0; i < 4; i++) chk(i_mem.m[56+i], 32'h5A00_0000 + i);
    wreg(cdw_pkg::OFF_MASK, 32'h2, cdw_pkg::RESP_OKAY);
    chk(irq, 1'b1);
    rreg(cdw_pkg::OFF_STAT, 32'hF, cdw_pkg::RESP_OKAY);
    chk(irq, 1'b0);
    // Receive pass with a stalling memory; polled descriptor re-armed
    slow <= 1'b1;
    wreg(cdw_pkg::OFF_CTRL, 32'h3, cdw_pkg::RESP_OKAY);
    i_mem.m[16] <= 32'h804F_0010;
    job(0, 32'h3000, 16'h000C, 1'b0);
    wm(16);
    chk(i_mem.m[16], 32'h004B_000C);
    rreg(cdw_pkg::OFF_CURR, 32'h40, cdw_pkg::RESP_OKAY);
    chk(irq, 1'b0);
    rreg(cdw_pkg::OFF_STAT, 32'h9, cdw_pkg::RESP_OKAY);
    print_verdict();
  end
endmodule
`default_nettype wire
